// file: hw/icc_top.sv
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
// ----------------------------------------
// Overview of operation
// - With stop_in_idle set modes 001 to 101 freeze in idle, otherwise they run on in idle; mode 111 still flags wake edges in idle.
// - A capture latches timer_two_count when timer_source_select is 1, else timer_three_count.
// - captures_per_interrupt picks an interrupt every 1st, 2nd, 3rd or 4th capture.
// - Read-only capture_overflow_flag shows 1 once an overflow has happened.
// - Read-only buffer_not_empty_flag shows 1 while an unread capture remains.
// - Mode 111 only raises an interrupt on rising edges during sleep or idle.
// - Modes 000 and 110 disable the channel: no captures, no interrupts.
// - Mode 101 captures every 16th rising edge, mode 100 every 4th.
// - Mode 011 captures every rising edge, mode 010 every falling edge.
// - Mode 001 captures both edges and interrupts on every capture.
// - Unimplemented control bits read zero and all state except the fifo_r storage words resets to zero.
// ----------------------------------------
module icc_top
   import icc_pkg::*;
(
   input  wire logic        i_mclk,
   input  wire logic        i_srst,
   input  wire logic [1:0]  i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   input  wire logic        i_cap_pin,
   input  wire logic        i_idle,
   input  wire logic        i_sleep,
   input  wire logic [15:0] i_timer_two_count,
   input  wire logic [15:0] i_timer_three_count,
   output logic      [15:0] o_rdata,
   output logic             o_irq
);

   typedef enum logic [1:0] {ICC_IDLE_RUN, ICC_IDLE_STOP} icc_run_e;

   logic                  stop_in_idle_r;
   logic                  timer_source_select_r;
   logic [1:0]            captures_per_interrupt_r;
   logic [2:0]            capture_mode_select_r;
   logic                  capture_overflow_flag_r;
   logic [15:0]           fifo_r [ICC_DEPTH];
   logic [ICC_PTR_W-1:0]  wptr_r;
   logic [ICC_PTR_W-1:0]  rptr_r;
   logic [2:0]            count_r;
   logic [3:0]            pre_r;
   logic [1:0]            ipc_r;
   logic                  pin_r;
   logic [2:0]            status_r;
   logic [2:0]            mask_r;
   logic                  run;
   logic                  rise;
   logic                  fall;
   logic                  edge_hit;
   logic                  cap_evt;
   logic                  cap_irq;
   logic                  wake_evt;
   logic                  pop;
   logic                  push;
   logic                  ovf_evt;
   logic                  mode_wr;
   logic [15:0]           ctrl_val;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic icc_mode_on(input logic [2:0] m);
      icc_mode_on = (m != ICC_M_OFF) && (m != ICC_M_UNUSED) && (m != ICC_M_WAKE);
   endfunction

   function automatic logic [1:0] icc_ipc_last(input logic [2:0] m, input logic [1:0] cpi);
      icc_ipc_last = (m == ICC_M_EVERY) ? 2'h0 : cpi;
   endfunction

   // ----------------------------------------
   // Edge detection and capture decision
   // ----------------------------------------
   // Channel frozen in idle when asked, and only capture modes count
   assign run      = icc_mode_on(capture_mode_select_r) &&
                     !(stop_in_idle_r && i_idle);
   assign rise     = i_cap_pin && !pin_r;
   assign fall     = !i_cap_pin && pin_r;
   assign mode_wr  = i_wr && (i_addr == ICC_ADDR_CTRL) &&
                     (i_wdata[2:0] != capture_mode_select_r);
   assign wake_evt = (capture_mode_select_r == ICC_M_WAKE) && rise &&
                     (i_sleep || i_idle);

   always_comb begin
      edge_hit = 1'b0;
      case (capture_mode_select_r)
         ICC_M_EVERY:  edge_hit = rise || fall;
         ICC_M_FALL:   edge_hit = fall;
         ICC_M_RISE:   edge_hit = rise;
         ICC_M_RISE4:  edge_hit = rise && (pre_r == ICC_PRE4_LAST);
         ICC_M_RISE16: edge_hit = rise && (pre_r == ICC_PRE16_LAST);
         default:      edge_hit = 1'b0;
      endcase
   end

   assign cap_evt = run && edge_hit;
   assign cap_irq = cap_evt &&
                    (ipc_r == icc_ipc_last(capture_mode_select_r,
                                           captures_per_interrupt_r));
   assign pop     = i_rd && (i_addr == ICC_ADDR_BUF) && (count_r != 3'h0);
   // A read in the same cycle frees the slot, so no capture is lost
   assign push    = cap_evt && ((count_r != ICC_FIFO_FULL) || pop);
   assign ovf_evt = cap_evt && (count_r == ICC_FIFO_FULL) && !pop;

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         pin_r <= 1'b0;
      end else begin
         pin_r <= i_cap_pin;
      end
   end

   // Prescaler counts rising edges; cleared on off or mode change
   always_ff @(posedge i_mclk) begin
      if (i_srst || mode_wr || !icc_mode_on(capture_mode_select_r)) begin
         pre_r <= 4'h0;
      end else if (run && rise) begin
         pre_r <= (capture_mode_select_r == ICC_M_RISE4 && pre_r == ICC_PRE4_LAST) ?
                  4'h0 : pre_r + 4'h1;
      end
   end

   // Captures-per-interrupt counter
   always_ff @(posedge i_mclk) begin
      if (i_srst || mode_wr || !icc_mode_on(capture_mode_select_r)) begin
         ipc_r <= 2'h0;
      end else if (cap_evt) begin
         ipc_r <= cap_irq ? 2'h0 : ipc_r + 2'h1;
      end
   end

   // ----------------------------------------
   // Control register
   // ----------------------------------------
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         stop_in_idle_r           <= ICC_CTRL_RST[ICC_BIT_SIDL];
         timer_source_select_r    <= ICC_CTRL_RST[ICC_BIT_TMR];
         captures_per_interrupt_r <= ICC_CTRL_RST[ICC_BIT_CPI_HI:ICC_BIT_CPI_LO];
         capture_mode_select_r    <= ICC_CTRL_RST[2:0];
      end else if (i_wr && i_addr == ICC_ADDR_CTRL) begin
         stop_in_idle_r           <= i_wdata[ICC_BIT_SIDL];
         timer_source_select_r    <= i_wdata[ICC_BIT_TMR];
         captures_per_interrupt_r <= i_wdata[ICC_BIT_CPI_HI:ICC_BIT_CPI_LO];
         capture_mode_select_r    <= i_wdata[2:0];
      end
   end

   // ----------------------------------------
   // Capture FIFO
   // ----------------------------------------
   // Full FIFO drops the new value to keep the oldest unread ones
   always_ff @(posedge i_mclk) begin
      if (push) begin
         fifo_r[wptr_r] <= timer_source_select_r ? i_timer_two_count
                                                 : i_timer_three_count;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         wptr_r  <= '0;
         rptr_r  <= '0;
         count_r <= 3'h0;
      end else begin
         if (push) begin
            wptr_r <= wptr_r + 2'h1;
         end
         if (pop) begin
            rptr_r <= rptr_r + 2'h1;
         end
         count_r <= count_r + {2'h0, push} - {2'h0, pop};
      end
   end

   // Overflow sticks until the mode is set to 000; mode 110 does not clear it
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         capture_overflow_flag_r <= 1'b0;
      end else if (ovf_evt) begin
         capture_overflow_flag_r <= 1'b1;
      end else if (capture_mode_select_r == ICC_M_OFF) begin
         capture_overflow_flag_r <= 1'b0;
      end
   end

   // ----------------------------------------
   // Interrupt status and mask
   // ----------------------------------------
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         status_r <= 3'h0;
      end else begin
         if (i_rd && i_addr == ICC_ADDR_STATUS) begin
            status_r <= 3'h0;
         end
         // Set wins over the read clear
         if (cap_irq) begin
            status_r[ICC_ST_CAP] <= 1'b1;
         end
         if (ovf_evt) begin
            status_r[ICC_ST_OVF] <= 1'b1;
         end
         if (wake_evt) begin
            status_r[ICC_ST_WAKE] <= 1'b1;
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         mask_r <= 3'h0;
      end else if (i_wr && i_addr == ICC_ADDR_MASK) begin
         mask_r <= i_wdata[2:0];
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(status_r & mask_r);
      end
   end

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   always_comb begin
      ctrl_val                                 = 16'h0000;
      ctrl_val[ICC_BIT_SIDL]                   = stop_in_idle_r;
      ctrl_val[ICC_BIT_TMR]                    = timer_source_select_r;
      ctrl_val[ICC_BIT_CPI_HI:ICC_BIT_CPI_LO]  = captures_per_interrupt_r;
      ctrl_val[ICC_BIT_OV]                     = capture_overflow_flag_r;
      ctrl_val[ICC_BIT_BNE]                    = (count_r != 3'h0);
      ctrl_val[2:0]                            = capture_mode_select_r;
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_rdata <= 16'h0000;
      end else if (i_rd) begin
         case (i_addr)
            ICC_ADDR_CTRL:   o_rdata <= ctrl_val;
            ICC_ADDR_BUF:    o_rdata <= (count_r != 3'h0) ? fifo_r[rptr_r] : 16'h0000;
            ICC_ADDR_STATUS: o_rdata <= {13'h0000, status_r};
            ICC_ADDR_MASK:   o_rdata <= {13'h0000, mask_r};
            default:         o_rdata <= 16'h0000;
         endcase
      end else begin
         o_rdata <= 16'h0000;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_off_no_capture;
      @(posedge i_mclk) disable iff (i_srst)
      !icc_mode_on(capture_mode_select_r) |-> !push && !cap_irq;
   endproperty
   a_off_no_capture: assert property (p_off_no_capture) else $error("off capture");

   property p_idle_stop;
      @(posedge i_mclk) disable iff (i_srst)
      (stop_in_idle_r && i_idle) |-> !cap_evt;
   endproperty
   a_idle_stop: assert property (p_idle_stop) else $error("capture in stopped idle");

   property p_bne;
      @(posedge i_mclk) disable iff (i_srst)
      push && !pop |=> ctrl_val[ICC_BIT_BNE];
   endproperty
   a_bne: assert property (p_bne) else $error("buffer flag not set");

   property p_ovf;
      @(posedge i_mclk) disable iff (i_srst)
      ovf_evt |=> capture_overflow_flag_r && status_r[ICC_ST_OVF];
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow not flagged");

   property p_every_irq;
      @(posedge i_mclk) disable iff (i_srst)
      (capture_mode_select_r == ICC_M_EVERY) && cap_evt |-> cap_irq;
   endproperty
   a_every_irq: assert property (p_every_irq) else $error("both-edge irq missed");

   property p_rise_cap;
      @(posedge i_mclk) disable iff (i_srst)
      (capture_mode_select_r == ICC_M_RISE) && run && rise && !mode_wr |-> cap_evt;
   endproperty
   a_rise_cap: assert property (p_rise_cap) else $error("rising edge missed");

   property p_pre4;
      @(posedge i_mclk) disable iff (i_srst)
      (capture_mode_select_r == ICC_M_RISE4) |-> pre_r <= ICC_PRE4_LAST;
   endproperty
   a_pre4: assert property (p_pre4) else $error("prescale by four overrun");

   property p_prezero;
      @(posedge i_mclk) disable iff (i_srst)
      mode_wr |=> pre_r == 4'h0 && ipc_r == 2'h0;
   endproperty
   a_prezero: assert property (p_prezero) else $error("prescaler not restarted");

   property p_irq_out;
      @(posedge i_mclk) disable iff (i_srst)
      (status_r[ICC_ST_CAP] && mask_r[ICC_ST_CAP]) |=> o_irq;
   endproperty
   a_irq_out: assert property (p_irq_out) else $error("irq not raised");

   sequence s_wake_edge;
      (capture_mode_select_r == ICC_M_WAKE) && i_cap_pin && !pin_r && (i_sleep || i_idle);
   endsequence

   property p_wake;
      @(posedge i_mclk) disable iff (i_srst)
      s_wake_edge |=> status_r[ICC_ST_WAKE];
   endproperty
   a_wake: assert property (p_wake) else $error("wake edge not flagged");

   property p_unimpl;
      @(posedge i_mclk) disable iff (i_srst)
      i_rd && (i_addr == ICC_ADDR_CTRL) |=>
         (o_rdata[15:ICC_BIT_SIDL+1] == '0) && (o_rdata[ICC_BIT_SIDL-1:ICC_BIT_TMR+1] == '0);
   endproperty
   a_unimpl: assert property (p_unimpl) else $error("unused bits not zero");

   property p_fifo_bound;
      @(posedge i_mclk) disable iff (i_srst)
      count_r <= ICC_FIFO_FULL;
   endproperty
   a_fifo_bound: assert property (p_fifo_bound) else $error("count overrun");

   property p_ovf_sticky;
      @(posedge i_mclk) disable iff (i_srst)
      capture_overflow_flag_r && (capture_mode_select_r != ICC_M_OFF) |=>
         capture_overflow_flag_r;
   endproperty
   a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow lost");

   // Empty buffer: the new word lands where the read pointer already stands
   sequence s_first_two;
      push && !pop && (count_r == 3'h0) && timer_source_select_r;
   endsequence

   property p_sel_two;
      @(posedge i_mclk) disable iff (i_srst)
      s_first_two |=> fifo_r[rptr_r] == $past(i_timer_two_count);
   endproperty
   a_sel_two: assert property (p_sel_two) else $error("wrong timer captured");

endmodule

// file: hw/icc_pkg.sv
package icc_pkg;
   // ----------------------------------------
   // Register map (word index on the plain port)
   // ----------------------------------------
   localparam logic [1:0]  ICC_ADDR_CTRL   = 2'h0;
   localparam logic [1:0]  ICC_ADDR_BUF    = 2'h1;
   localparam logic [1:0]  ICC_ADDR_STATUS = 2'h2;
   localparam logic [1:0]  ICC_ADDR_MASK   = 2'h3;
   // ----------------------------------------
   // Control field positions
   // ----------------------------------------
   localparam int          ICC_BIT_SIDL    = 13;
   localparam int          ICC_BIT_TMR     = 7;
   localparam int          ICC_BIT_CPI_HI  = 6;
   localparam int          ICC_BIT_CPI_LO  = 5;
   localparam int          ICC_BIT_OV      = 4;
   localparam int          ICC_BIT_BNE     = 3;
   // ----------------------------------------
   // Modes, reset values, sizes
   // ----------------------------------------
   localparam logic [2:0]  ICC_M_OFF       = 3'h0;
   localparam logic [2:0]  ICC_M_EVERY     = 3'h1;
   localparam logic [2:0]  ICC_M_FALL      = 3'h2;
   localparam logic [2:0]  ICC_M_RISE      = 3'h3;
   localparam logic [2:0]  ICC_M_RISE4     = 3'h4;
   localparam logic [2:0]  ICC_M_RISE16    = 3'h5;
   localparam logic [2:0]  ICC_M_UNUSED    = 3'h6;
   localparam logic [2:0]  ICC_M_WAKE      = 3'h7;
   localparam logic [15:0] ICC_CTRL_RST    = 16'h0000;
   localparam logic [3:0]  ICC_PRE4_LAST   = 4'h3;
   localparam logic [3:0]  ICC_PRE16_LAST  = 4'hF;
   localparam int          ICC_DEPTH       = 4;
   localparam int          ICC_PTR_W       = 2;
   localparam logic [2:0]  ICC_FIFO_FULL   = 3'h4;
   // Status bits: 0 capture interrupt, 1 overflow, 2 wake edge
   localparam int          ICC_ST_CAP      = 0;
   localparam int          ICC_ST_OVF      = 1;
   localparam int          ICC_ST_WAKE     = 2;
endpackage

// file: dv/icc_pin_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Capture pin source
// ----------------------------------------
module icc_pin_model (
   input  wire logic       i_mclk,
   input  wire logic       i_start,
   input  wire logic [7:0] i_count,
   input  wire logic [3:0] i_gap,
   output logic            o_pin,
   output logic            o_busy
);
   logic [7:0] left_r = 8'h00;
   logic [3:0] wait_r = 4'h0;
   initial o_pin = 1'b0;
   assign o_busy = (left_r != 8'h00);
   // Gap spaces edges out to mimic a slow signal
   always @(posedge i_mclk) begin
      if (i_start) begin
         left_r <= i_count;
         wait_r <= i_gap;
      end else if (left_r != 8'h00) begin
         if (wait_r == 4'h0) begin
            o_pin  <= ~o_pin;
            left_r <= left_r - 8'h01;
            wait_r <= i_gap;
         end else begin
            wait_r <= wait_r - 4'h1;
         end
      end
   end
endmodule

// file: dv/tb_icc_top.sv
`timescale 1ns/100ps
module tb_icc_top;
   import icc_pkg::*;
   logic        i_mclk, i_srst, i_wr, i_rd, i_idle, i_sleep, pin, busy, start, o_irq, tsel;
   logic [1:0]  i_addr;
   logic [15:0] i_wdata, t2, t3, o_rdata, tv, last;
   logic [7:0]  cnt;
   logic [3:0]  gap;
   int          seed = 32'hE8CC;
   int          bad_count = 0;
   int          total_checks = 0;
   int          n;
   icc_top dut_u (.i_mclk(i_mclk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .i_cap_pin(pin), .i_idle(i_idle), .i_sleep(i_sleep),
      .i_timer_two_count(t2), .i_timer_three_count(t3), .o_rdata(o_rdata), .o_irq(o_irq));
   icc_pin_model pin_u (.i_mclk(i_mclk), .i_start(start), .i_count(cnt), .i_gap(gap),
      .o_pin(pin), .o_busy(busy));
   initial begin
      i_mclk = 1'b0;
      forever #50 i_mclk = ~i_mclk;
   end
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic int ncap(input logic [2:0] m, input int t);
      case (m)
         ICC_M_EVERY: return t;
         ICC_M_FALL, ICC_M_RISE: return t / 2;
         ICC_M_RISE4: return t / 8;
         ICC_M_RISE16: return t / 32;
         default: return 0;
      endcase
   endfunction
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge i_mclk);
      i_addr  <= a;
      i_wdata <= d;
      i_wr    <= 1'b1;
      @(posedge i_mclk);
      i_wr    <= 1'b0;
   endtask
   // Read data lives only in the cycle after the strobe
   task automatic rdq(input logic [1:0] a);
      @(posedge i_mclk);
      i_addr <= a;
      i_rd   <= 1'b1;
      @(posedge i_mclk);
      i_rd   <= 1'b0;
      #1 last = o_rdata;
   endtask
   task automatic rd(input logic [1:0] a, input logic [15:0] exp);
      rdq(a);
      chk(last, exp);
   endtask
   // Leftover captures would spoil the next test
   task automatic clean();
      wr(ICC_ADDR_CTRL, 16'h0000);
      repeat (4) rdq(ICC_ADDR_BUF);
      rdq(ICC_ADDR_STATUS);
   endtask
   task automatic edges(input int t);
      int k;
      @(posedge i_mclk);
      start <= 1'b1;
      cnt   <= 8'(t);
      gap   <= 4'($random(seed) & 3);
      @(posedge i_mclk);
      start <= 1'b0;
      #1;
      for (k = 0; k < 3000 && busy !== 1'b0; k++) @(posedge i_mclk);
      if (k == 3000) begin
         bad_count++;
         conclude();
      end else
         repeat (3) @(posedge i_mclk);
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {i_wr, i_rd, i_idle, i_sleep, start, i_addr, i_wdata, cnt, gap} = '0;
      t2 = 16'h0000;
      t3 = 16'h0000;
      i_srst = 1'b1;
      repeat (6) @(posedge i_mclk);
      i_srst <= 1'b0;
      for (int a = 0; a < 4; a++) rd(2'(a), 16'h0000);
      wr(ICC_ADDR_BUF, 16'hFFFF);
      wr(ICC_ADDR_STATUS, 16'hFFFF);
      rd(ICC_ADDR_BUF, 16'h0000);
      rd(ICC_ADDR_STATUS, 16'h0000);
      wr(ICC_ADDR_CTRL, 16'hFFFF);
      rd(ICC_ADDR_CTRL, 16'h20E7);
      $display("test regs done");
      for (int m = 0; m < 8; m++) begin
         clean();
         wr(ICC_ADDR_MASK, 16'h0001);
         @(posedge i_mclk);
         t2   <= 16'($random(seed));
         t3   <= 16'($random(seed));
         tsel = 1'($random(seed));
         wr(ICC_ADDR_CTRL, {8'h00, tsel, 4'h0, 3'(m)});
         edges(32);
         n  = ncap(3'(m), 32);
         tv = tsel ? t2 : t3;
         chk({15'h0, o_irq}, 16'(n > 0));
         rd(ICC_ADDR_CTRL, {8'h00, tsel, 2'b00, n > 4, n > 0, 3'(m)});
         rd(ICC_ADDR_STATUS, {14'h0, n > 4, n > 0});
         for (int j = 0; j < 4; j++) rd(ICC_ADDR_BUF, (j < n) ? tv : 16'h0000);
         rd(ICC_ADDR_CTRL, {8'h00, tsel, 2'b00, n > 4, 1'b0, 3'(m)});
         chk({15'h0, o_irq}, 16'h0000);
      end
      $display("test modes done");
      for (int c = 0; c < 4; c++) begin
         clean();
         wr(ICC_ADDR_CTRL, {9'h000, 2'(c), 2'b00, ICC_M_RISE});
         edges(2 * c);
         rd(ICC_ADDR_STATUS, 16'h0000);
         edges(2);
         rd(ICC_ADDR_STATUS, 16'h0001);
      end
      clean();
      wr(ICC_ADDR_CTRL, {9'h000, 2'b11, 2'b00, ICC_M_EVERY});
      edges(1);
      rd(ICC_ADDR_STATUS, 16'h0001);
      edges(1);
      rd(ICC_ADDR_STATUS, 16'h0001);
      $display("test interrupt count done");
      clean();
      @(posedge i_mclk);
      i_idle <= 1'b1;
      wr(ICC_ADDR_CTRL, 16'h2003);
      edges(2);
      rd(ICC_ADDR_CTRL, 16'h2003);
      wr(ICC_ADDR_CTRL, 16'h0003);
      edges(2);
      rd(ICC_ADDR_CTRL, 16'h000B);
      clean();
      @(posedge i_mclk);
      i_idle <= 1'b0;
      $display("test idle done");
      wr(ICC_ADDR_MASK, 16'h0004);
      @(posedge i_mclk);
      i_sleep <= 1'b1;
      wr(ICC_ADDR_CTRL, 16'h00E7);
      edges(2);
      chk({15'h0, o_irq}, 16'h0001);
      rd(ICC_ADDR_STATUS, 16'h0004);
      rd(ICC_ADDR_CTRL, 16'h00E7);
      @(posedge i_mclk);
      i_sleep <= 1'b0;
      edges(2);
      rd(ICC_ADDR_STATUS, 16'h0000);
      @(posedge i_mclk);
      i_idle <= 1'b1;
      wr(ICC_ADDR_CTRL, 16'h2007);
      edges(2);
      rd(ICC_ADDR_STATUS, 16'h0004);
      @(posedge i_mclk);
      i_idle <= 1'b0;
      wr(ICC_ADDR_MASK, 16'h0000);
      @(posedge i_mclk);
      i_sleep <= 1'b1;
      edges(2);
      chk({15'h0, o_irq}, 16'h0000);
      rd(ICC_ADDR_STATUS, 16'h0004);
      @(posedge i_mclk);
      i_sleep <= 1'b0;
      $display("test wake done");
      clean();
      wr(ICC_ADDR_CTRL, {13'h0000, ICC_M_RISE4});
      edges(6);
      wr(ICC_ADDR_CTRL, {13'h0000, ICC_M_RISE16});
      wr(ICC_ADDR_CTRL, {13'h0000, ICC_M_RISE4});
      edges(6);
      rd(ICC_ADDR_CTRL, {13'h0000, ICC_M_RISE4});
      edges(2);
      rd(ICC_ADDR_CTRL, {12'h000, 1'b1, ICC_M_RISE4});
      $display("test prescaler done");
      wr(ICC_ADDR_MASK, 16'h0007);
      wr(ICC_ADDR_CTRL, 16'h2083);
      edges(2);
      chk({15'h0, o_irq}, 16'h0001);
      @(posedge i_mclk);
      i_srst <= 1'b1;
      repeat (2) @(posedge i_mclk);
      i_srst <= 1'b0;
      chk({15'h0, o_irq}, 16'h0000);
      for (int a = 0; a < 4; a++) rd(2'(a), 16'h0000);
      $display("test reset done");
      conclude();
   end
endmodule
